// [hdl/ofc_flash_ctrl.sv]
// Purpose: Flash sequencer with protection, user words and status flags.
// Assumes: Array read data is valid the cycle after o_arr_rd is seen high.
// Notes:   Committed settings live in the array config page and reload after reset.
//
// Decided for this implementation: the strobed register port and the address map.
`include "ofc_defs.svh"
module ofc_flash_ctrl
  import ofc_pkg::*;
#(
  parameter int                 BLOCK_KB  = 1,
  parameter logic [`OFC_TW-1:0] ERASE_CYC = `OFC_TW'(`OFC_ERASE_CYC)
) (
  input  wire logic               i_clk,
  input  wire logic               i_nrst,
  input  wire logic [7:0]         i_addr,
  input  wire logic [31:0]        i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic      [31:0]        o_rdata,
  input  wire logic               i_hr_req,
  input  wire logic [`OFC_AW-1:0] i_hr_addr,
  input  wire logic               i_hr_fetch,
  output logic                    o_hr_valid,
  output logic                    o_hr_err,
  output logic      [31:0]        o_hr_data,
  output logic      [`OFC_AW-1:0] o_arr_addr,
  output logic                    o_arr_cfg,
  output logic                    o_arr_rd,
  output logic                    o_arr_we,
  output logic      [31:0]        o_arr_wdata,
  input  wire logic [31:0]        i_arr_rdata,
  input  wire logic               i_arr_fail,
  input  wire logic               i_vdd_ok,
  input  wire logic               i_eeprom_irq,
  output logic                    o_busy,
  output logic                    o_irq
);
  // Block geometry follows the build-time block size.
  localparam int BW_LOG = $clog2(BLOCK_KB * `OFC_WPKB);
  localparam logic [`OFC_AW-1:0] BMASK = `OFC_AW'((1 << BW_LOG) - 1);

  ofc_state_t              state_reg;
  ofc_op_t                 op_reg;
  logic [`OFC_AW-1:0]      cur_reg;
  logic [`OFC_AW-1:0]      last_reg;
  logic                    cfg_reg;
  logic [31:0]             word_reg;
  logic [`OFC_AW-1:0]      addr_reg;
  logic [31:0]             data_reg;
  logic [31:0]             prot_reg;
  logic [31:0]             user_reg [4];
  logic [`OFC_NFLAG-1:0]   ris_reg;
  logic [`OFC_NFLAG-1:0]   im_reg;
  logic                    rej_reg;
  logic                    hr1_v_reg;
  logic                    hr1_e_reg;
  logic                    hr2_v_reg;
  logic                    hr2_e_reg;

  logic [2:0]              cmd_code;
  logic                    cmd_go;
  logic                    wr_cmd;
  logic                    deny_wr;
  logic [1:0]              tgt_lvl;
  logic                    hr_take;
  logic                    hr_deny;
  logic                    vdd_bad;
  logic                    data_bad;
  logic                    prot_wr;
  logic                    prot_bad;
  logic                    tmr_start;
  logic                    tmr_done;
  logic [`OFC_TW-1:0]      tmr_cycles;
  logic [31:0]             wsel;
  logic [1:0]              uidx;
  logic [`OFC_NFLAG-1:0]   ev;
  logic [`OFC_NFLAG-1:0]   clr;
  logic [`OFC_NFLAG-1:0]   ris_nx;
  logic [31:0]             stat_w;

  // Protection level of the block holding a word address.
  function automatic logic [1:0] lvl_of(input logic [31:0] pw, input logic [`OFC_AW-1:0] a);
    logic [`OFC_AW-1:0] b;
    b = a >> BW_LOG;
    return pw[{b[3:0], 1'b0} +: 2];
  endfunction

  // Command decode and the protection gate in front of erase and program.
  always_comb begin
    cmd_code = i_wdata[2:0];
    tgt_lvl  = lvl_of(prot_reg, addr_reg);
    cmd_go   = i_wr && (i_addr == `OFC_A_CMD) && (state_reg == S_IDLE);
    wr_cmd   = cmd_go && ((cmd_code == `OFC_CMD_ERASE) || (cmd_code == `OFC_CMD_PROG));
    deny_wr  = wr_cmd && (tgt_lvl != `OFC_PL_RW);
    hr_take  = i_hr_req && (state_reg == S_IDLE);
    hr_deny  = i_hr_req && !i_hr_fetch && (lvl_of(prot_reg, i_hr_addr) == `OFC_PL_XO);
    vdd_bad  = !i_vdd_ok && ((state_reg == S_TIME) || (state_reg == S_WR));
    data_bad = |(~i_arr_rdata & data_reg);
  end

  // Protection write check: any loosened or illegal field rejects the whole word.
  always_comb begin
    prot_wr  = i_wr && (i_addr == `OFC_A_PROT);
    prot_bad = |(i_wdata & ~prot_reg);
    for (int k = 0; k < `OFC_NBLK_MAX; k++) begin
      if (i_wdata[2*k +: 2] == `OFC_PL_BAD) begin
        prot_bad = 1'b1;
      end
    end
  end

  // Timer launch: erase and commit start from idle, program after its check.
  always_comb begin
    tmr_start = (cmd_go && !deny_wr && (cmd_code != `OFC_CMD_PROG) &&
                 (cmd_code >= `OFC_CMD_ERASE) && (cmd_code <= `OFC_CMD_CUSER)) ||
                ((state_reg == S_RDC) && (op_reg == OP_PROG) && !data_bad);
    tmr_cycles = ((state_reg == S_IDLE) && (cmd_code == `OFC_CMD_ERASE)) ?
                 ERASE_CYC : `OFC_TW'(`OFC_PROG_CYC);
  end

  // The controller owns every array pulse width; software only starts it.
  ofc_timer u_timer (
    .i_clk    (i_clk),
    .i_nrst   (i_nrst),
    .i_start  (tmr_start),
    .i_stop   (vdd_bad),
    .i_cycles (tmr_cycles),
    .o_done   (tmr_done)
  );

  // Sequencer; after reset it first reloads the committed config words.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= S_RD;
      op_reg    <= OP_LOAD;
      cur_reg   <= `OFC_CFG_PROT;
      last_reg  <= `OFC_CFG_LAST;
      cfg_reg   <= 1'b1;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (cmd_go && !deny_wr) begin
            if (cmd_code == `OFC_CMD_ERASE) begin
              op_reg    <= OP_ERASE;
              cur_reg   <= addr_reg & ~BMASK;
              last_reg  <= addr_reg | BMASK;
              cfg_reg   <= 1'b0;
              state_reg <= S_TIME;
            end else if (cmd_code == `OFC_CMD_PROG) begin
              op_reg    <= OP_PROG;
              cur_reg   <= addr_reg;
              last_reg  <= addr_reg;
              cfg_reg   <= 1'b0;
              state_reg <= S_RD;
            end else if (cmd_code == `OFC_CMD_CPROT) begin
              op_reg    <= OP_COMMIT;
              cur_reg   <= `OFC_CFG_PROT;
              last_reg  <= `OFC_CFG_PROT;
              cfg_reg   <= 1'b1;
              state_reg <= S_TIME;
            end else if (cmd_code == `OFC_CMD_CUSER) begin
              op_reg    <= OP_COMMIT;
              cur_reg   <= `OFC_CFG_USER;
              last_reg  <= `OFC_CFG_LAST;
              cfg_reg   <= 1'b1;
              state_reg <= S_TIME;
            end
          end
        end
        S_TIME: begin
          if (vdd_bad) begin
            state_reg <= S_IDLE;
          end else if (tmr_done) begin
            state_reg <= S_WR;
          end
        end
        S_RD:  state_reg <= S_RDW;
        S_RDW: state_reg <= S_RDC;
        S_RDC: begin
          if (op_reg == OP_LOAD) begin
            if (cur_reg == last_reg) begin
              state_reg <= S_IDLE;
            end else begin
              cur_reg   <= cur_reg + 12'h001;
              state_reg <= S_RD;
            end
          end else if (data_bad) begin
            state_reg <= S_IDLE;
          end else begin
            state_reg <= S_TIME;
          end
        end
        S_WR: begin
          if (vdd_bad || (cur_reg == last_reg)) begin
            state_reg <= S_IDLE;
          end else begin
            cur_reg <= cur_reg + 12'h001;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Program merges new data into the old word, so no bit can rise.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      word_reg <= `OFC_ONES;
    end else if ((state_reg == S_RDC) && (op_reg == OP_PROG)) begin
      word_reg <= i_arr_rdata & data_reg;
    end
  end

  // Write data per operation: ones for erase, merged word, or config word.
  always_comb begin
    uidx = cur_reg[1:0] - 2'h1;
    if (op_reg == OP_ERASE) begin
      wsel = `OFC_ONES;
    end else if (op_reg == OP_PROG) begin
      wsel = word_reg;
    end else if (cur_reg == `OFC_CFG_PROT) begin
      wsel = prot_reg;
    end else begin
      wsel = user_reg[uidx];
    end
  end

  // Array port; host reads use it only while the sequencer is idle.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arr_addr  <= '0;
      o_arr_cfg   <= 1'b0;
      o_arr_rd    <= 1'b0;
      o_arr_we    <= 1'b0;
      o_arr_wdata <= '0;
    end else begin
      o_arr_rd    <= (hr_take && !hr_deny) || (state_reg == S_RD);
      o_arr_we    <= (state_reg == S_WR) && i_vdd_ok;
      o_arr_addr  <= hr_take ? i_hr_addr : cur_reg;
      o_arr_cfg   <= hr_take ? 1'b0 : cfg_reg;
      o_arr_wdata <= wsel;
    end
  end

  // Host read pipeline; busy or denied reads answer with an error, no data.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hr1_v_reg  <= 1'b0;
      hr1_e_reg  <= 1'b0;
      hr2_v_reg  <= 1'b0;
      hr2_e_reg  <= 1'b0;
      o_hr_valid <= 1'b0;
      o_hr_err   <= 1'b0;
      o_hr_data  <= '0;
    end else begin
      hr1_v_reg  <= i_hr_req;
      hr1_e_reg  <= !hr_take || hr_deny;
      hr2_v_reg  <= hr1_v_reg;
      hr2_e_reg  <= hr1_e_reg;
      o_hr_valid <= hr2_v_reg;
      o_hr_err   <= hr2_e_reg;
      o_hr_data  <= (hr2_v_reg && !hr2_e_reg) ? i_arr_rdata : '0;
    end
  end

  // Run-time protection: reset to open, then reload committed levels.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prot_reg <= `OFC_ONES;
      rej_reg  <= 1'b0;
    end else if ((state_reg == S_RDC) && (op_reg == OP_LOAD) && (cur_reg == `OFC_CFG_PROT)) begin
      prot_reg <= i_arr_rdata;
    end else if (prot_wr) begin
      rej_reg <= prot_bad;
      if (!prot_bad) begin
        prot_reg <= i_wdata;
      end
    end
  end

  // User words are volatile until committed; reload restores committed ones.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int u = 0; u < 4; u++) begin
        user_reg[u] <= `OFC_ONES;
      end
    end else if ((state_reg == S_RDC) && (op_reg == OP_LOAD) && (cur_reg != `OFC_CFG_PROT)) begin
      user_reg[uidx] <= i_arr_rdata;
    end else if (i_wr && (i_addr[7:4] == `OFC_A_USER_HI) && (i_addr[1:0] == 2'h0)) begin
      user_reg[i_addr[3:2]] <= i_wdata;
    end
  end

  // Flag events and write-one-to-clear; a same-cycle event beats its clear.
  always_comb begin
    ev = '0;
    ev[`OFC_F_ACC]   = deny_wr || hr_deny;
    ev[`OFC_F_DONE]  = (state_reg == S_WR) && (cur_reg == last_reg) && i_vdd_ok;
    ev[`OFC_F_EEP]   = i_eeprom_irq;
    ev[`OFC_F_VOLT]  = vdd_bad;
    ev[`OFC_F_DATA]  = (state_reg == S_RDC) && (op_reg == OP_PROG) && data_bad;
    ev[`OFC_F_ERASE] = (state_reg == S_WR) && i_arr_fail && (op_reg == OP_ERASE);
    ev[`OFC_F_PROG]  = (state_reg == S_WR) && i_arr_fail && (op_reg != OP_ERASE);
    clr    = (i_wr && (i_addr == `OFC_A_ICLR)) ? i_wdata[`OFC_NFLAG-1:0] : '0;
    ris_nx = (ris_reg & ~clr) | ev;
  end

  // Flags, mask, and the interrupt line gated by the mask.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ris_reg <= '0;
      im_reg  <= '0;
      o_irq   <= 1'b0;
      o_busy  <= 1'b1;
    end else begin
      ris_reg <= ris_nx;
      if (i_wr && (i_addr == `OFC_A_IM)) begin
        im_reg <= i_wdata[`OFC_NFLAG-1:0];
      end
      o_irq  <= |(ris_nx & im_reg);
      o_busy <= (state_reg != S_IDLE);
    end
  end

  // Status word.
  always_comb begin
    stat_w = '0;
    stat_w[`OFC_ST_BUSY] = (state_reg != S_IDLE);
    stat_w[`OFC_ST_REJ]  = rej_reg;
  end

  // Address and data registers for the next command.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_reg <= '0;
      data_reg <= `OFC_ONES;
    end else if (i_wr && (i_addr == `OFC_A_ADDR)) begin
      addr_reg <= i_wdata[`OFC_AW-1:0];
    end else if (i_wr && (i_addr == `OFC_A_DATA)) begin
      data_reg <= i_wdata;
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= '0;
    end else if (!i_rd) begin
      o_rdata <= '0;
    end else if (i_addr == `OFC_A_ADDR) begin
      o_rdata <= {20'h00000, addr_reg};
    end else if (i_addr == `OFC_A_DATA) begin
      o_rdata <= data_reg;
    end else if (i_addr == `OFC_A_STAT) begin
      o_rdata <= stat_w;
    end else if (i_addr == `OFC_A_RIS) begin
      o_rdata <= {25'h0000000, ris_reg};
    end else if (i_addr == `OFC_A_IM) begin
      o_rdata <= {25'h0000000, im_reg};
    end else if (i_addr == `OFC_A_MIS) begin
      o_rdata <= {25'h0000000, ris_reg & im_reg};
    end else if (i_addr == `OFC_A_PROT) begin
      o_rdata <= prot_reg;
    end else if ((i_addr[7:4] == `OFC_A_USER_HI) && (i_addr[1:0] == 2'h0)) begin
      o_rdata <= user_reg[i_addr[3:2]];
    end else begin
      o_rdata <= '0;
    end
  end

  // Checks on the sequencer and flag logic.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_erase_start;
    (state_reg == S_IDLE) ##1 (state_reg == S_TIME) && (op_reg == OP_ERASE);
  endsequence
  sequence s_last_write;
    (state_reg == S_WR) && (cur_reg == last_reg) && i_vdd_ok && !i_arr_fail;
  endsequence

  AST_ERASE_ONES: assert property (
    o_arr_we && (op_reg == OP_ERASE) |-> o_arr_wdata == `OFC_ONES)
    else $error("erase wrote a word other than all ones");
  AST_DENY_WR: assert property (
    deny_wr |=> (state_reg == S_IDLE) && ris_reg[`OFC_F_ACC] && !o_arr_we)
    else $error("protected block was not refused");
  AST_XO_READ: assert property (
    i_hr_req && hr_deny |-> ##3 o_hr_valid && o_hr_err && (o_hr_data == '0))
    else $error("execute-only data read was served");
  AST_PROG_ONE: assert property (
    (state_reg == S_WR) && (op_reg == OP_PROG) |-> (cur_reg == last_reg) ##1 (state_reg == S_IDLE))
    else $error("program touched more than one word");
  AST_MERGE: assert property (
    (state_reg == S_RDC) && (op_reg == OP_PROG) |=> word_reg == ($past(i_arr_rdata) & data_reg))
    else $error("program word could raise a bit");
  AST_DATA_ERR: assert property (
    ev[`OFC_F_DATA] |=> ris_reg[`OFC_F_DATA] && (state_reg == S_IDLE) ##1 !o_arr_we)
    else $error("zero to one request was not flagged and stopped");
  AST_VOLT: assert property (
    vdd_bad |=> (state_reg == S_IDLE) && ris_reg[`OFC_F_VOLT] && !o_arr_we)
    else $error("bad supply did not abort the operation");
  AST_DONE: assert property (
    s_last_write |=> ris_reg[`OFC_F_DONE] && (state_reg == S_IDLE) ##1 !o_busy)
    else $error("completion was not flagged");
  AST_TIMED: assert property (
    s_erase_start |-> ((state_reg == S_TIME) || !i_vdd_ok) [*8])
    else $error("erase did not wait for its timer");
  AST_CLR: assert property (
    (clr != '0) && (ev == '0) |=> ris_reg == ($past(ris_reg) & ~$past(clr)))
    else $error("clear changed flags it did not name");
  AST_IRQ: assert property (
    ((ris_reg & im_reg) != '0) && $stable(im_reg) |-> o_irq)
    else $error("enabled flag did not raise the interrupt");
  AST_MASKED: assert property (
    ((ris_reg & im_reg) == '0) && $stable(im_reg) |-> !o_irq)
    else $error("disabled flag reached the interrupt");
  AST_LOOSEN: assert property (
    prot_wr && prot_bad && (state_reg != S_RDC) |=> prot_reg == $past(prot_reg) && rej_reg)
    else $error("protection was loosened");
  AST_ONE_OP: assert property (
    i_wr && (i_addr == `OFC_A_CMD) && (state_reg != S_IDLE) |=> op_reg == $past(op_reg))
    else $error("second operation started while busy");
endmodule

// [hdl/ofc_timer.sv]
// Purpose: Down counter that times array program and erase pulses.
// Assumes: i_cycles is at least one.
// Notes:   o_done pulses i_cycles edges after the start edge.
`include "ofc_defs.svh"
module ofc_timer
  import ofc_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_nrst,
  input  wire logic               i_start,
  input  wire logic               i_stop,
  input  wire logic [`OFC_TW-1:0] i_cycles,
  output logic                    o_done
);
  localparam logic [`OFC_TW-1:0] ONE = `OFC_TW'(1);

  logic [`OFC_TW-1:0] cnt_reg;
  logic               run_reg;

  // A stop beats a running count so an abort never leaves a stale done.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        cnt_reg <= i_cycles - ONE;
        run_reg <= 1'b1;
      end else if (i_stop) begin
        run_reg <= 1'b0;
      end else if (run_reg) begin
        if (cnt_reg == '0) begin
          run_reg <= 1'b0;
          o_done  <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - ONE;
        end
      end
    end
  end
endmodule

// [inc/ofc_defs.svh]
// Purpose: Constants for the on-chip flash controller.
// Assumes: 40 MHz clock, 16 KB array of 32-bit words, erased bits read one.
// Notes:   Word addresses throughout; config words live in a separate array page.
// Function
// - Erase leaves whole block all ones.
// - Read-only blocks refuse erase and program.
// - Execute-only blocks serve instruction fetches only.
// - Program writes exactly one word.
// - Program only clears bits to zero.
// - Repeated programs allowed without erase.
// - Controller times program and erase itself.
// - Invalid accesses raise an interrupt source.
// - Protected program or erase sets access flag.
// - Completion flag on each finished cycle.
// - Bad supply aborts operation, sets voltage flag.
// - Zero-to-one program request sets data flag.
// - Failed erase sets erase-error flag.
// - Failed program sets program-error flag.
// - One flag mirrors companion EEPROM interrupt.
// - Clear affects only named flags.
// - Protection changes act now, persist on commit.
// - Four volatile user registers until committed.
// - Committed user values survive reset.
// - Block size parameter: 1 or 16 KB.
// - Only enabled flags reach interrupt line.
// - Protection may only become stricter.
// - Uncommitted protection reverts at reset.
`ifndef OFC_DEFS_SVH
`define OFC_DEFS_SVH

// Register offsets.
`define OFC_A_ADDR    8'h00
`define OFC_A_DATA    8'h04
`define OFC_A_CMD     8'h08
`define OFC_A_STAT    8'h0c
`define OFC_A_RIS     8'h10
`define OFC_A_IM      8'h14
`define OFC_A_MIS     8'h18
`define OFC_A_ICLR    8'h1c
`define OFC_A_PROT    8'h20
`define OFC_A_USER_HI 4'h3

// Status bits and flag bits.
`define OFC_ST_BUSY 0
`define OFC_ST_REJ  1
`define OFC_NFLAG   7
`define OFC_F_ACC   0
`define OFC_F_DONE  1
`define OFC_F_EEP   2
`define OFC_F_VOLT  3
`define OFC_F_DATA  4
`define OFC_F_ERASE 5
`define OFC_F_PROG  6

// Command codes.
`define OFC_CMD_ERASE 3'h1
`define OFC_CMD_PROG  3'h2
`define OFC_CMD_CPROT 3'h3
`define OFC_CMD_CUSER 3'h4

// Protection levels; stricter levels only clear bits.
`define OFC_PL_RW  2'h3
`define OFC_PL_RO  2'h2
`define OFC_PL_BAD 2'h1
`define OFC_PL_XO  2'h0

// Geometry and config page layout.
`define OFC_AW        12
`define OFC_FLASH_KB  16
`define OFC_WPKB      256
`define OFC_NBLK_MAX  16
`define OFC_ONES      32'hffffffff
`define OFC_CFG_PROT  12'h000
`define OFC_CFG_USER  12'h001
`define OFC_CFG_LAST  12'h004

// Timing.
`define OFC_TW         20
`define OFC_CLK_NS     25
`define OFC_T_PROG_NS  20000
`define OFC_T_ERASE_NS 10000000
`define OFC_PROG_CYC   ((`OFC_T_PROG_NS + `OFC_CLK_NS - 1) / `OFC_CLK_NS)
`define OFC_ERASE_CYC  ((`OFC_T_ERASE_NS + `OFC_CLK_NS - 1) / `OFC_CLK_NS)

`endif

// [inc/ofc_pkg.sv]
// Purpose: Types shared by the flash controller modules.
// Assumes: Nothing beyond the defs header.
// Notes:   State and operation enumerations only.
package ofc_pkg;
  typedef enum logic [2:0] {S_IDLE, S_TIME, S_RD, S_RDW, S_RDC, S_WR} ofc_state_t;
  typedef enum logic [1:0] {OP_LOAD, OP_ERASE, OP_PROG, OP_COMMIT} ofc_op_t;
endpackage

// [tb/ofc_array_model.sv]
// Purpose: Behavioural flash array with a main page and a config page.
// Assumes: Read data is wanted only in the cycle after the read strobe.
// Notes:   Nothing here is reset, so stored words outlive a controller reset.
module ofc_array_model (
  input  wire logic        i_clk,
  input  wire logic [11:0] i_addr,
  input  wire logic        i_cfg,
  input  wire logic        i_rd,
  input  wire logic        i_we,
  input  wire logic [31:0] i_wdata,
  output logic      [31:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [4096];
  logic [31:0] cfg [8];
  // Erased cells read as ones from power-up.
  initial begin
    foreach (mem[i]) mem[i] = 32'hffffffff;
    foreach (cfg[i]) cfg[i] = 32'hffffffff;
    o_rdata = 32'h0;
  end
  // The bus toggles outside the answer cycle, so a sample one cycle late reads the inverted word.
  always @(posedge i_clk) begin
    if (i_we && i_cfg) begin
      cfg[i_addr[2:0]] <= i_wdata;
    end else if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    if (i_rd) begin
      o_rdata <= i_cfg ? cfg[i_addr[2:0]] : mem[i_addr];
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule

// [tb/ofc_flash_ctrl_tb_top.sv]
// Purpose: Self-checking bench for the flash controller and its array.
// Assumes: 40 MHz clock, one-kilobyte blocks, erase time cut to 20 cycles.
// Notes:   Cases run in order; later ones rely on earlier array contents.
`include "ofc_defs.svh"
module ofc_flash_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, wr, rd, hreq, hfetch, valid, herr, cfg, ard, awe, fail, vdd, eirq;
  logic        busy, irq;
  logic [7:0]  addr;
  logic [11:0] haddr, aaddr;
  logic [31:0] wdata, rdata, hdata, awdata, ardata;
  int          fails = 0, checks_done = 0, cyc = 0;
  logic [71:0] rows [4] = '{{8'h14, 32'h7f, 32'h7f}, {8'h30, 32'h12345678, 32'h12345678},
                            {8'h3c, 32'ha5a5a5a5, 32'ha5a5a5a5}, {8'h44, 32'h1, 32'h0}};
  ofc_flash_ctrl #(.BLOCK_KB(1), .ERASE_CYC(`OFC_TW'(20))) u_ofc_flash_ctrl (
    .i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_hr_req(hreq), .i_hr_addr(haddr), .i_hr_fetch(hfetch),
    .o_hr_valid(valid), .o_hr_err(herr), .o_hr_data(hdata), .o_arr_addr(aaddr),
    .o_arr_cfg(cfg), .o_arr_rd(ard), .o_arr_we(awe), .o_arr_wdata(awdata),
    .i_arr_rdata(ardata), .i_arr_fail(fail), .i_vdd_ok(vdd), .i_eeprom_irq(eirq),
    .o_busy(busy), .o_irq(irq));
  ofc_array_model u_ofc_array_model (.i_clk(clk), .i_addr(aaddr), .i_cfg(cfg), .i_rd(ard),
    .i_we(awe), .i_wdata(awdata), .o_rdata(ardata));
  // Free-running clock at 25 ns.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // A hang ends the run through the same report as a normal finish.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      report_and_stop();
    end
  end
  // Shared checks and bus cycles follow.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  // The answer is due exactly three cycles after the request cycle.
  task automatic hread(input logic [11:0] a, input logic f, input logic e, input logic [31:0] d);
    @(posedge clk);
    hreq   <= 1'b1;
    haddr  <= a;
    hfetch <= f;
    @(posedge clk);
    hreq <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({30'h0, valid, herr}, {30'h0, 1'b1, e});
    chk(hdata, d);
  endtask
  task automatic idle();
    repeat (2) @(posedge clk);
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge clk);
  endtask
  task automatic op(input logic [11:0] a, input logic [31:0] d, input logic [2:0] c);
    wreg(`OFC_A_ADDR, {20'h0, a});
    wreg(`OFC_A_DATA, d);
    wreg(`OFC_A_CMD, {29'h0, c});
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    #1 chk({31'h0, busy}, 32'h1);
    idle();
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence: table rows first, then the hand-written cases.
  initial begin
    {wr, rd, hreq, hfetch, fail, eirq, addr, wdata, haddr} = '0;
    vdd  = 1'b1;
    nrst = 1'b0;
    do_reset();
    rreg(`OFC_A_PROT, 32'hffffffff, 32'hffffffff);
    foreach (rows[i]) begin
      wreg(rows[i][71:64], rows[i][63:32]);
      rreg(rows[i][71:64], 32'hffffffff, rows[i][31:0]);
    end
    $display("registers done");
    op(12'h005, 32'hffff00ff, `OFC_CMD_PROG);
    @(posedge clk);
    #1 chk({31'h0, busy}, 32'h1);
    wreg(`OFC_A_CMD, 32'h1);
    idle();
    rreg(`OFC_A_RIS, 32'h7f, 32'h02);
    chk({31'h0, irq}, 32'h1);
    hread(12'h005, 1'b0, 1'b0, 32'hffff00ff);
    hread(12'h006, 1'b0, 1'b0, 32'hffffffff);
    wreg(`OFC_A_ICLR, 32'h02);
    rreg(`OFC_A_RIS, 32'h7f, 32'h0);
    chk({31'h0, irq}, 32'h0);
    op(12'h005, 32'h0f0000ff, `OFC_CMD_PROG);
    idle();
    hread(12'h005, 1'b0, 1'b0, 32'h0f0000ff);
    op(12'h005, 32'h0f00ff00, `OFC_CMD_PROG);
    idle();
    rreg(`OFC_A_RIS, 32'h10, 32'h10);
    hread(12'h005, 1'b0, 1'b0, 32'h0f0000ff);
    $display("program done");
    wreg(`OFC_A_ICLR, 32'h7f);
    op(12'h005, 32'h0f000000, `OFC_CMD_PROG);
    repeat (10) @(posedge clk);
    vdd <= 1'b0;
    idle();
    vdd <= 1'b1;
    rreg(`OFC_A_RIS, 32'h0a, 32'h08);
    hread(12'h005, 1'b0, 1'b0, 32'h0f0000ff);
    @(posedge clk);
    fail <= 1'b1;
    op(12'h006, 32'h0, `OFC_CMD_PROG);
    idle();
    op(12'h006, 32'h0, `OFC_CMD_ERASE);
    idle();
    fail <= 1'b0;
    rreg(`OFC_A_RIS, 32'h60, 32'h60);
    wreg(`OFC_A_ICLR, 32'h7f);
    op(12'h005, 32'h0, `OFC_CMD_ERASE);
    idle();
    rreg(`OFC_A_RIS, 32'h7f, 32'h02);
    hread(12'h005, 1'b0, 1'b0, 32'hffffffff);
    hread(12'h0ff, 1'b1, 1'b0, 32'hffffffff);
    $display("faults and erase done");
    @(posedge clk);
    eirq <= 1'b1;
    wreg(`OFC_A_IM, 32'h0);
    rreg(`OFC_A_RIS, 32'h04, 32'h04);
    chk({31'h0, irq}, 32'h0);
    wreg(`OFC_A_IM, 32'h04);
    rreg(`OFC_A_MIS, 32'h7f, 32'h04);
    chk({31'h0, irq}, 32'h1);
    @(posedge clk);
    eirq <= 1'b0;
    wreg(`OFC_A_PROT, 32'hfffffffe);
    wreg(`OFC_A_ICLR, 32'h7f);
    op(12'h005, 32'h0, `OFC_CMD_PROG);
    idle();
    rreg(`OFC_A_RIS, 32'h7f, 32'h01);
    hread(12'h005, 1'b0, 1'b0, 32'hffffffff);
    wreg(`OFC_A_PROT, 32'hffffffff);
    rreg(`OFC_A_STAT, 32'h02, 32'h02);
    rreg(`OFC_A_PROT, 32'hffffffff, 32'hfffffffe);
    wreg(`OFC_A_PROT, 32'hfffffffc);
    wreg(`OFC_A_ICLR, 32'h7f);
    wreg(`OFC_A_IM, 32'h01);
    hread(12'h005, 1'b0, 1'b1, 32'h0);
    rreg(`OFC_A_RIS, 32'h01, 32'h01);
    chk({31'h0, irq}, 32'h1);
    hread(12'h005, 1'b1, 1'b0, 32'hffffffff);
    $display("interrupts and protection done");
    wreg(`OFC_A_CMD, 32'h3);
    idle();
    wreg(`OFC_A_CMD, 32'h4);
    idle();
    wreg(`OFC_A_PROT, 32'hfffffff8);
    wreg(8'h34, 32'h0);
    do_reset();
    rreg(`OFC_A_PROT, 32'hffffffff, 32'hfffffffc);
    rreg(8'h30, 32'hffffffff, 32'h12345678);
    rreg(8'h3c, 32'hffffffff, 32'ha5a5a5a5);
    rreg(8'h34, 32'hffffffff, 32'hffffffff);
    $display("commit done");
    report_and_stop();
  end
endmodule
